// >>> rtl/lia_cfg.svh
`ifndef LIA_CFG_SVH
`define LIA_CFG_SVH

`define LIA_IDX_W 11
`define LIA_IDX_MASTER_EN 11'h433
`define LIA_IDX_TC_OVF_EN 11'h434
`define LIA_IDX_STAT_BASE 11'h435
`define LIA_IDX_EN_BASE 11'h445
`define LIA_IDX_MASTER_REQ 11'h455
`define LIA_IDX_TC_OVF_ST 11'h456
`define LIA_IDX_GRP_OVF_ST 11'h457
`define LIA_NUM_LINKS 16
`define LIA_NUM_GROUPS 8
`define LIA_STAT_W 12
`define LIA_BIT_GRP_OVF 8
`define LIA_BIT_TX_READY 7
`define LIA_BIT_CNT_OVF 0
`define LIA_STAT_WMASK 12'hefe
`define LIA_RST_16 16'h0000
`define LIA_RST_12 12'h000
`define LIA_RST_8 8'h00

`endif

// >>> rtl/lia_pkg.sv
package lia_pkg;
	// Per-link event strobes, one field per status bit 11:1 except bits 8 and 7
	typedef struct packed {
		logic delay_sync_loss_end;
		logic frame_loss_end;
		logic cell_delineation_loss_end;
		logic preproc_overflow;
		logic cell_changes;
		logic control_cell_violation;
		logic delay_sync_loss;
		logic frame_loss;
		logic cell_delineation_loss;
	} lia_link_ev_t;

	typedef struct packed {
		logic [10:0] idx;
		logic write;
		logic mapped;
	} lia_bus_req_t;

	typedef enum logic {
		LIA_BUS_IDLE,
		LIA_BUS_WAIT
	} lia_bus_st_t;
endpackage

// >>> rtl/lia_top.sv
`timescale 1ns/1ps
`include "lia_cfg.svh"
module lia_top #(
	parameter int NUM_LINKS = `LIA_NUM_LINKS,
	parameter int NUM_GROUPS = `LIA_NUM_GROUPS
) (
	input wire logic ref_clk, // 25 MHz clock
	input wire logic sys_rst, // Sync reset, active high
	input wire logic hsel, // AHB slave select
	input wire logic [31:0] haddr, // AHB address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size
	input wire logic hready, // AHB bus ready
	input wire logic [31:0] hwdata, // AHB write data
	output logic [31:0] hrdata, // AHB read data
	output logic hreadyout, // AHB slave ready
	output logic hresp, // AHB response, always OKAY
	input wire lia_pkg::lia_link_ev_t [NUM_LINKS-1:0] link_events, // Per-link event strobes
	input wire logic [NUM_LINKS-1:0] counter_overflow, // Link counter overflowed
	input wire logic [NUM_LINKS-1:0] counter_serviced, // Offending counter read or written
	input wire logic [NUM_LINKS-1:0] tc_overflow_event, // Link overflow source
	input wire logic [NUM_GROUPS-1:0] group_overflow_event, // Group counter or FIFO overflow
	input wire logic tx_ready_return, // A group transmit ready flag returned to 1
	input wire logic group_frame_pulse, // A group frame pulse seen
	output logic irq_n // Interrupt pin, active low
);
	import lia_pkg::*;

	lia_bus_st_t bus_st;
	lia_bus_req_t req;
	logic [`LIA_STAT_W-1:0] link_status [NUM_LINKS];
	logic [`LIA_STAT_W-1:0] link_enable [NUM_LINKS];
	logic [NUM_LINKS-1:0] master_enable;
	logic [NUM_LINKS-1:0] tc_ovf_enable;
	logic [NUM_LINKS-1:0] tc_ovf_status;
	logic [NUM_GROUPS-1:0] group_ovf_status;
	logic [NUM_LINKS-1:0] master_req;
	logic [15:0] wdata;
	logic wr_go;
	logic rd_go;
	logic grp_pending;
	logic [15:0] rd_value;
	logic addr_phase;

	assign addr_phase = hsel && htrans[1] && hready;
	assign wdata = hwdata[15:0];
	assign wr_go = (bus_st == LIA_BUS_WAIT) && req.write && req.mapped;
	assign rd_go = (bus_st == LIA_BUS_WAIT) && !req.write;
	assign grp_pending = |group_ovf_status;

	// Bus slave: one wait state so read data leaves a flop
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			bus_st <= LIA_BUS_IDLE;
			req <= '0;
			hreadyout <= 1'b1;
		end else begin
			case (bus_st)
				LIA_BUS_IDLE: begin
					if (addr_phase) begin
						req.idx <= haddr[12:2];
						req.write <= hwrite;
						req.mapped <= (haddr[31:13] == 19'h00000) && (haddr[1:0] == 2'h0);
						hreadyout <= 1'b0;
						bus_st <= LIA_BUS_WAIT;
					end
				end
				LIA_BUS_WAIT: begin
					hreadyout <= 1'b1;
					bus_st <= LIA_BUS_IDLE;
				end
				default: begin
					hreadyout <= 1'b1;
					bus_st <= LIA_BUS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			hrdata <= 32'h00000000;
		end else if (rd_go) begin
			hrdata <= {16'h0000, req.mapped ? rd_value : 16'h0000};
		end
	end

	// Read mux; unmapped indices read zero
	always_comb begin
		rd_value = 16'h0000;
		if (req.idx == `LIA_IDX_MASTER_EN) begin
			rd_value = 16'(master_enable);
		end else if (req.idx == `LIA_IDX_TC_OVF_EN) begin
			rd_value = 16'(tc_ovf_enable);
		end else if (req.idx == `LIA_IDX_MASTER_REQ) begin
			rd_value = 16'(master_req);
		end else if (req.idx == `LIA_IDX_TC_OVF_ST) begin
			rd_value = 16'(tc_ovf_status);
		end else if (req.idx == `LIA_IDX_GRP_OVF_ST) begin
			rd_value = {8'h00, 8'(group_ovf_status)};
		end else begin
			for (int k = 0; k < NUM_LINKS; k++) begin
				if (req.idx == 11'(`LIA_IDX_STAT_BASE + k)) begin
					rd_value = {4'h0, link_status[k]};
					if (k == 0) begin
						rd_value[`LIA_BIT_GRP_OVF] = grp_pending;
					end
				end
				if (req.idx == 11'(`LIA_IDX_EN_BASE + k)) begin
					rd_value = {4'h0, link_enable[k]};
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			master_enable <= NUM_LINKS'(`LIA_RST_16);
		end else if (wr_go && req.idx == `LIA_IDX_MASTER_EN) begin
			master_enable <= wdata[NUM_LINKS-1:0];
		end
	end

	// Receive clock must be running when software touches this one
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tc_ovf_enable <= NUM_LINKS'(`LIA_RST_16);
		end else if (wr_go && req.idx == `LIA_IDX_TC_OVF_EN) begin
			tc_ovf_enable <= wdata[NUM_LINKS-1:0];
		end
	end

	// Sticky overflow status per link; a new event beats a written 0
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tc_ovf_status <= NUM_LINKS'(`LIA_RST_16);
		end else if (wr_go && req.idx == `LIA_IDX_TC_OVF_ST) begin
			tc_ovf_status <= (tc_ovf_status & wdata[NUM_LINKS-1:0]) | tc_overflow_event;
		end else begin
			tc_ovf_status <= tc_ovf_status | tc_overflow_event;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			group_ovf_status <= NUM_GROUPS'(`LIA_RST_8);
		end else if (wr_go && req.idx == `LIA_IDX_GRP_OVF_ST) begin
			group_ovf_status <= (group_ovf_status & wdata[NUM_GROUPS-1:0]) | group_overflow_event;
		end else begin
			group_ovf_status <= group_ovf_status | group_overflow_event;
		end
	end

	genvar i;
	generate
		for (i = 0; i < NUM_LINKS; i++) begin : g_link
			logic [`LIA_STAT_W-1:0] set_v;
			logic [`LIA_STAT_W-1:0] clr_v;
			logic stat_hit;
			logic en_hit;
			logic ready_ev;

			assign stat_hit = wr_go && (req.idx == 11'(`LIA_IDX_STAT_BASE + i));
			assign en_hit = wr_go && (req.idx == 11'(`LIA_IDX_EN_BASE + i));
			// Ready and frame events exist only on link 0
			assign ready_ev = (i == 0) ? (tx_ready_return | group_frame_pulse) : 1'b0;

			assign set_v = {
				link_events[i].delay_sync_loss_end,
				link_events[i].frame_loss_end,
				link_events[i].cell_delineation_loss_end,
				1'b0,
				ready_ev,
				link_events[i].preproc_overflow,
				link_events[i].cell_changes,
				link_events[i].control_cell_violation,
				link_events[i].delay_sync_loss,
				link_events[i].frame_loss,
				link_events[i].cell_delineation_loss,
				counter_overflow[i]
			};

			// Written zeros clear writable bits; bit 0 clears only when its counter is serviced
			always_comb begin
				clr_v = stat_hit ? (~wdata[`LIA_STAT_W-1:0] & `LIA_STAT_WMASK) : `LIA_RST_12;
				clr_v[`LIA_BIT_CNT_OVF] = counter_serviced[i];
			end

			always_ff @(posedge ref_clk) begin
				if (sys_rst) begin
					link_status[i] <= `LIA_RST_12;
				end else begin
					link_status[i] <= (link_status[i] & ~clr_v) | set_v;
				end
			end

			always_ff @(posedge ref_clk) begin
				if (sys_rst) begin
					link_enable[i] <= `LIA_RST_12;
				end else if (en_hit) begin
					link_enable[i] <= wdata[`LIA_STAT_W-1:0];
				end
			end

			// Group pending flag counts as bit 8 of link 0 only
			always_comb begin
				logic [`LIA_STAT_W-1:0] eff;
				eff = link_status[i];
				eff[`LIA_BIT_GRP_OVF] = (i == 0) ? grp_pending : 1'b0;
				master_req[i] = |(eff & link_enable[i]) || (tc_ovf_status[i] && tc_ovf_enable[i]);
			end
		end
	endgenerate

	// Pin is unlatched request gated by enable, registered once
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			irq_n <= 1'b1;
		end else begin
			irq_n <= ~|(master_req & master_enable);
		end
	end
endmodule

// >>> dv/lia_props.sv
`timescale 1ns/1ps
`include "lia_cfg.svh"
module lia_props (
	input wire logic ref_clk, // Clock
	input wire logic sys_rst, // Reset
	input wire logic hsel, // Select
	input wire logic [31:0] haddr, // Address
	input wire logic [1:0] htrans, // Type
	input wire logic hwrite, // Write
	input wire logic hready, // Ready in
	input wire logic [31:0] hwdata, // Write data
	input wire logic [31:0] hrdata, // Read data
	input wire logic hreadyout, // Ready out
	input wire logic hresp, // Response
	input wire logic irq_n // Interrupt
);
	logic [10:0] idx;
	logic wr, act, done;
	logic [15:0] men;
	wire take = hsel && htrans[1] && hready && hreadyout;
	wire rd = done && !wr;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// Follow transfers and master enable writes
	always_ff @(posedge ref_clk) begin
		act <= take && !sys_rst;
		done <= act;
		if (take) begin
			idx <= haddr[12:2];
			wr <= hwrite;
		end
		if (sys_rst) begin
			men <= 16'h0;
		end else if (act && wr && idx == `LIA_IDX_MASTER_EN) begin
			men <= hwdata[15:0];
		end
	end
	a_ready_low: assert property (take |=> !hreadyout ##1 hreadyout)
		else $error("ready pulse wrong");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	a_rd_hold: assert property (!act |=> $stable(hrdata))
		else $error("read data moved");
	a_unused_zero: assert property (rd && idx >= 11'h435 && idx <= 11'h454 |-> hrdata[15:12] == 4'h0)
		else $error("unused bits set");
	a_grp_upper: assert property (rd && idx == 11'h457 |-> hrdata[15:8] == 8'h00)
		else $error("group upper bits set");
	a_link0_only: assert property (rd && idx > 11'h435 && idx < 11'h445 |-> hrdata[8:7] == 2'h0)
		else $error("link0 bits on other link");
	a_irq_needs_en: assert property (!irq_n |-> $past(men) != 16'h0)
		else $error("irq without enable");
	a_irq_masked: assert property (men == 16'h0 |=> irq_n)
		else $error("irq stays low");
	c_read: cover property (rd);
	c_irq: cover property (!irq_n);
	c_write: cover property (act && wr);
endmodule
bind lia_top lia_props u_lia_props (.*);

// >>> dv/lia_host.sv
`timescale 1ns/1ps
module lia_host (
	input wire logic ref_clk, // Clock
	input wire logic hreadyout, // Ready
	input wire logic [31:0] hrdata, // Read data
	output logic hsel, // Select
	output logic [31:0] haddr, // Address
	output logic [1:0] htrans, // Type
	output logic hwrite, // Write
	output logic [2:0] hsize, // Size
	output logic [31:0] hwdata // Write data
);
	// Receive clock taken as always running
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	task automatic xfer(input logic [10:0] i, input logic w, input logic [15:0] d, output logic [15:0] q);
		@(posedge ref_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {19'h0, i, 2'h0};
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {16'h0, d};
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		q = hrdata[15:0];
		hwdata <= ~hwdata;
	endtask
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import lia_pkg::*;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic hsel, hwrite, hreadyout, hresp, irq_n, txr = 1'b0, gfp = 1'b0;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata;
	lia_link_ev_t [15:0] ev = '0;
	logic [15:0] c_ovf = '0, c_srv = '0, tc_ev = '0, q;
	logic [7:0] g_ev = '0;
	int n_fail = 0, checked = 0;
	lia_top u_lia_top (.ref_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout),
		.hwdata, .hrdata, .hreadyout, .hresp, .link_events(ev), .counter_overflow(c_ovf),
		.counter_serviced(c_srv), .tc_overflow_event(tc_ev), .group_overflow_event(g_ev),
		.tx_ready_return(txr), .group_frame_pulse(gfp), .irq_n);
	lia_host u_lia_host (.ref_clk, .hreadyout, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
	initial forever #20 ref_clk = ~ref_clk;
	task automatic wrap_up;
		if (n_fail == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic rd(input logic [10:0] i, input logic [15:0] e);
		u_lia_host.xfer(i, 1'b0, 16'h0, q);
		chk($sformatf("reg %h", i), e, q);
	endtask
	task automatic wr(input logic [10:0] i, input logic [15:0] d);
		u_lia_host.xfer(i, 1'b1, d, q);
	endtask
	task automatic s_regs;
		rd(11'h455, 16'h0);
		wr(11'h0, 16'hffff);
		rd(11'h0, 16'h0);
		wr(11'h445, 16'hffff);
		rd(11'h445, 16'h0fff);
		wr(11'h445, 16'h0);
		wr(11'h434, 16'hffff);
		rd(11'h434, 16'hffff);
		wr(11'h434, 16'h0);
	endtask
	task automatic s_link;
		@(posedge ref_clk) ev[3] <= '1;
		c_ovf[3] <= 1'b1;
		@(posedge ref_clk) ev[3] <= '0;
		c_ovf[3] <= 1'b0;
		rd(11'h438, 16'h0e7f);
		wr(11'h438, 16'hfffd);
		rd(11'h438, 16'h0e7d);
		wr(11'h438, 16'h0);
		rd(11'h438, 16'h0001);
		@(posedge ref_clk) c_srv[3] <= 1'b1;
		@(posedge ref_clk) c_srv[3] <= 1'b0;
		rd(11'h438, 16'h0);
	endtask
	task automatic s_link0;
		@(posedge ref_clk) txr <= 1'b1;
		@(posedge ref_clk) txr <= 1'b0;
		rd(11'h435, 16'h0080);
		wr(11'h435, 16'h0);
		@(posedge ref_clk) gfp <= 1'b1;
		@(posedge ref_clk) gfp <= 1'b0;
		g_ev[7] <= 1'b1;
		@(posedge ref_clk) g_ev[7] <= 1'b0;
		rd(11'h435, 16'h0180);
		rd(11'h436, 16'h0);
		rd(11'h457, 16'h0080);
		wr(11'h435, 16'h0);
		rd(11'h435, 16'h0100);
		wr(11'h457, 16'h0);
		rd(11'h435, 16'h0);
	endtask
	task automatic s_irq;
		wr(11'h448, 16'h0010);
		@(posedge ref_clk) ev[3].control_cell_violation <= 1'b1;
		@(posedge ref_clk) ev[3].control_cell_violation <= 1'b0;
		rd(11'h455, 16'h0008);
		chk("irq_n", 16'h1, irq_n);
		wr(11'h455, 16'h0);
		rd(11'h455, 16'h0008);
		wr(11'h433, 16'h0008);
		@(posedge ref_clk);
		chk("irq_n", 16'h0, irq_n);
		wr(11'h448, 16'h0020);
		@(posedge ref_clk);
		chk("irq_n", 16'h1, irq_n);
		@(posedge ref_clk) tc_ev[9] <= 1'b1;
		@(posedge ref_clk) tc_ev[9] <= 1'b0;
		rd(11'h455, 16'h0);
		wr(11'h434, 16'h0200);
		rd(11'h455, 16'h0200);
	endtask
	initial begin
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'b0;
		s_regs;
		s_link;
		s_link0;
		s_irq;
		wrap_up;
	end
	initial begin
		repeat (5000) @(posedge ref_clk);
		n_fail++;
		wrap_up;
	end
endmodule
